// ==== dcr_pkg.sv ====
// dcr_pkg: offsets, field positions, reset values and carrier types of the channel control bank
package dcr_pkg;
  localparam int NUM_CHAN = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register addresses
  localparam logic [7:0] ADDR_CHANNEL_SELECT = 8'h00;
  localparam logic [7:0] ADDR_GLOBAL_FUNCTION_TWO = 8'h02;
  localparam logic [7:0] ADDR_CHANNEL_FUNCTION = 8'h03;
  localparam logic [7:0] ADDR_FREQ_WORD_ZERO = 8'h04;
  localparam logic [7:0] ADDR_PHASE_OFFSET_ZERO = 8'h05;
  localparam logic [7:0] ADDR_AMPLITUDE_CONTROL = 8'h06;
  localparam logic [7:0] ADDR_SWEEP_RAMP_RATE = 8'h07;
  localparam logic [7:0] ADDR_RISING_DELTA = 8'h08;
  localparam logic [7:0] ADDR_FALLING_DELTA = 8'h09;

  // reset values
  localparam logic [7:0] RST_CHANNEL_SELECT = 8'hF0;
  localparam logic [15:0] RST_GLOBAL_FUNCTION_TWO = 16'h0000;

  // channel select fields
  localparam int CS_ENABLE_LSB = 4;

  // global function two fields
  localparam int GF_CLR_PHASE = 12;
  localparam int GF_AUTO_PHASE = 13;
  localparam int GF_CLR_SWEEP = 14;
  localparam int GF_AUTO_SWEEP = 15;

  // channel function fields
  localparam int CF_SINE = 0;
  localparam int CF_CLR_PHASE = 1;
  localparam int CF_AUTO_PHASE = 2;
  localparam int CF_CLR_SWEEP = 3;
  localparam int CF_AUTO_SWEEP = 4;
  localparam int CF_MATCH_PIPE = 5;
  localparam int CF_DAC_PD = 6;
  localparam int CF_DIG_PD = 7;
  localparam int CF_DAC_LSB_LO = 8;
  localparam int CF_MUST_ZERO = 10;
  localparam int CF_SWEEP_LOAD = 13;
  localparam int CF_SWEEP_EN = 14;
  localparam int CF_NO_DWELL = 15;
  localparam int CF_MOD_LO = 22;

  // phase offset word
  localparam int POW_W = 14;

  // amplitude control fields
  localparam int AC_ASF_W = 10;
  localparam int AC_LOAD = 10;
  localparam int AC_AUTO = 11;
  localparam int AC_MULT_EN = 12;
  localparam int AC_STEP_LO = 14;
  localparam int AC_RATE_LO = 16;

  typedef struct packed {
    logic [23:0] channel_function;
    logic [31:0] channel_frequency_word_zero;
    logic [15:0] channel_phase_offset_zero;
    logic [23:0] amplitude_control;
    logic [15:0] sweep_ramp_rate;
    logic [31:0] rising_delta_word;
    logic [31:0] falling_delta_word;
  } dcr_chan_regs_t;

  localparam dcr_chan_regs_t RST_CHAN_REGS = '0;

  typedef struct packed {
    logic phase_clear;
    logic phase_autoclear;
    logic sweep_clear;
    logic sweep_autoclear;
    logic sine_sel;
    logic match_pipe;
    logic dac_powerdown;
    logic digital_powerdown;
    logic [1:0] dac_lsb;
    logic sweep_timer_load;
    logic sweep_enable;
    logic no_dwell;
    logic [1:0] mod_type;
    logic [31:0] freq_word;
    logic [13:0] phase_word;
    logic [9:0] amp_scale;
    logic amp_mult_enable;
    logic amplitude_ramp_updown;
    logic amp_timer_load;
    logic [1:0] amp_step;
    logic [7:0] amp_rate;
    logic [15:0] sweep_rate;
    logic [31:0] rising_delta;
    logic [31:0] falling_delta;
  } dcr_chan_ctl_t;
endpackage : dcr_pkg

// ==== dcr_channel_regs.sv ====
// dcr_channel_regs: buffered per-channel and global control registers of the synthesizer
module dcr_channel_regs
  import dcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_update,
  input wire logic [3:0] i_profile,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_rvalid,
  output logic [7:0] o_channel_select,
  output dcr_chan_ctl_t [NUM_CHAN-1:0] o_ctl
);

  // merge one host write into a channel's buffered copy
  function automatic dcr_chan_regs_t chan_write(input dcr_chan_regs_t r,
                                                input logic [ADDR_W-1:0] a,
                                                input logic [DATA_W-1:0] d);
    dcr_chan_regs_t n;
    n = r;
    case (a)
      ADDR_CHANNEL_FUNCTION: n.channel_function = d[23:0];
      ADDR_FREQ_WORD_ZERO: n.channel_frequency_word_zero = d;
      ADDR_PHASE_OFFSET_ZERO: n.channel_phase_offset_zero = d[15:0];
      ADDR_AMPLITUDE_CONTROL: n.amplitude_control = d[23:0];
      ADDR_SWEEP_RAMP_RATE: n.sweep_ramp_rate = d[15:0];
      ADDR_RISING_DELTA: n.rising_delta_word = d;
      ADDR_FALLING_DELTA: n.falling_delta_word = d;
      default: n = r;
    endcase
    return n;
  endfunction : chan_write

  // read view of a channel's buffered copy
  function automatic logic [DATA_W-1:0] chan_read(input dcr_chan_regs_t r,
                                                  input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    v = '0;
    case (a)
      ADDR_CHANNEL_FUNCTION: v = {8'h00, r.channel_function};
      ADDR_FREQ_WORD_ZERO: v = r.channel_frequency_word_zero;
      ADDR_PHASE_OFFSET_ZERO: v = {18'h00000, r.channel_phase_offset_zero[POW_W-1:0]};
      ADDR_AMPLITUDE_CONTROL: v = {8'h00, r.amplitude_control};
      ADDR_SWEEP_RAMP_RATE: v = {16'h0000, r.sweep_ramp_rate};
      ADDR_RISING_DELTA: v = r.rising_delta_word;
      ADDR_FALLING_DELTA: v = r.falling_delta_word;
      default: v = '0;
    endcase
    return v;
  endfunction : chan_read

  logic [7:0] channel_select;
  logic [15:0] gf_buf;
  logic [15:0] gf_act;
  dcr_chan_regs_t chan_buf [NUM_CHAN];
  dcr_chan_regs_t chan_act [NUM_CHAN];
  logic [2:0] upd_sync;
  logic upd_level;
  logic upd_pulse;
  logic [3:0] prof_sync [3];
  logic [3:0] prof_level;
  logic prof_change;
  logic [1:0] read_chan;

  // channel enables apply at once, no update needed
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      channel_select <= RST_CHANNEL_SELECT;
    end else if (i_wr && i_addr == ADDR_CHANNEL_SELECT) begin
      channel_select <= i_wdata[7:0];
    end
  end

  // update pin: three flops, a rise counts once the last two agree
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      upd_sync <= '0;
      upd_level <= 1'b0;
      upd_pulse <= 1'b0;
    end else begin
      upd_sync <= {upd_sync[1:0], i_update};
      if (upd_sync[1] == upd_sync[2]) begin
        upd_level <= upd_sync[2];
      end
      upd_pulse <= (upd_sync[1] == upd_sync[2]) && upd_sync[2] && !upd_level;
    end
  end

  // profile pins, same filtering; any settled change is one event
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      prof_sync[0] <= '0;
      prof_sync[1] <= '0;
      prof_sync[2] <= '0;
      prof_level <= '0;
      prof_change <= 1'b0;
    end else begin
      prof_sync[0] <= i_profile;
      prof_sync[1] <= prof_sync[0];
      prof_sync[2] <= prof_sync[1];
      if (prof_sync[1] == prof_sync[2]) begin
        prof_level <= prof_sync[2];
      end
      prof_change <= (prof_sync[1] == prof_sync[2]) && (prof_sync[2] != prof_level);
    end
  end

  // global buffer takes host writes at once
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      gf_buf <= RST_GLOBAL_FUNCTION_TWO;
    end else if (i_wr && i_addr == ADDR_GLOBAL_FUNCTION_TWO) begin
      gf_buf <= i_wdata[15:0];
    end
  end

  // active global copy moves only on an update
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      gf_act <= RST_GLOBAL_FUNCTION_TWO;
    end else if (upd_pulse) begin
      gf_act <= gf_buf;
    end
  end

  // per-channel buffers; a write in the update cycle lands for the next update
  always_ff @(posedge i_clk) begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (i_reset) begin
        chan_buf[c] <= RST_CHAN_REGS;
      end else if (i_wr && channel_select[CS_ENABLE_LSB+c]) begin
        chan_buf[c] <= chan_write(chan_buf[c], i_addr, i_wdata);
      end
    end
  end

  // active channel copies move only on an update
  always_ff @(posedge i_clk) begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (i_reset) begin
        chan_act[c] <= RST_CHAN_REGS;
      end else if (upd_pulse) begin
        chan_act[c] <= chan_buf[c];
      end
    end
  end

  // reads come from the lowest enabled channel, channel 0 if none
  always_comb begin
    read_chan = 2'd0;
    for (int c = NUM_CHAN - 1; c >= 0; c--) begin
      if (channel_select[CS_ENABLE_LSB+c]) begin
        read_chan = c[1:0];
      end
    end
  end

  // read strobe answered one cycle later
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
    end
  end

  // read data holds until the next read
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      if (i_addr == ADDR_CHANNEL_SELECT) begin
        o_rdata <= {24'h000000, channel_select};
      end else if (i_addr == ADDR_GLOBAL_FUNCTION_TWO) begin
        o_rdata <= {16'h0000, gf_buf};
      end else begin
        o_rdata <= chan_read(chan_buf[read_chan], i_addr);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_channel_select <= RST_CHANNEL_SELECT;
    end else begin
      o_channel_select <= channel_select;
    end
  end

  // control outputs, one flop behind the active copy; clears are levels
  // the auto-clear and timer-load pulses use the values being transferred by that update
  logic [NUM_CHAN-1:0] phase_clear;
  logic [NUM_CHAN-1:0] sweep_clear;
  logic [NUM_CHAN-1:0] phase_autoclear;
  logic [NUM_CHAN-1:0] sweep_autoclear;
  logic [NUM_CHAN-1:0] sweep_timer_load;
  logic [NUM_CHAN-1:0] amp_timer_load;
  logic [NUM_CHAN-1:0] sine_sel;
  logic [NUM_CHAN-1:0] match_pipe;
  logic [NUM_CHAN-1:0] dac_powerdown;
  logic [NUM_CHAN-1:0] digital_powerdown;
  logic [1:0] dac_lsb [NUM_CHAN];
  logic [NUM_CHAN-1:0] sweep_enable;
  logic [NUM_CHAN-1:0] no_dwell;
  logic [1:0] mod_type [NUM_CHAN];
  logic [31:0] freq_word [NUM_CHAN];
  logic [POW_W-1:0] phase_word [NUM_CHAN];
  logic [15:0] sweep_rate [NUM_CHAN];
  logic [31:0] rising_delta [NUM_CHAN];
  logic [31:0] falling_delta [NUM_CHAN];
  logic [AC_ASF_W-1:0] amp_scale [NUM_CHAN];
  logic [NUM_CHAN-1:0] amp_mult_enable;
  logic [NUM_CHAN-1:0] amplitude_ramp_updown;
  logic [1:0] amp_step [NUM_CHAN];
  logic [7:0] amp_rate [NUM_CHAN];

  // clears are levels so the accumulators can clear asynchronously
  always_ff @(posedge i_clk) begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (i_reset) begin
        phase_clear[c] <= 1'h0;
        sweep_clear[c] <= 1'h0;
      end else begin
        phase_clear[c] <= gf_act[GF_CLR_PHASE]
                          | chan_act[c].channel_function[CF_CLR_PHASE];
        sweep_clear[c] <= gf_act[GF_CLR_SWEEP]
                          | chan_act[c].channel_function[CF_CLR_SWEEP];
      end
    end
  end

  // one-cycle pulses; profile reloads use the active copy, no update involved
  always_ff @(posedge i_clk) begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (i_reset) begin
        phase_autoclear[c] <= 1'h0;
        sweep_autoclear[c] <= 1'h0;
        sweep_timer_load[c] <= 1'h0;
        amp_timer_load[c] <= 1'h0;
      end else begin
        phase_autoclear[c] <= upd_pulse && (gf_buf[GF_AUTO_PHASE]
                              || chan_buf[c].channel_function[CF_AUTO_PHASE]);
        sweep_autoclear[c] <= upd_pulse && (gf_buf[GF_AUTO_SWEEP]
                              || chan_buf[c].channel_function[CF_AUTO_SWEEP]);
        sweep_timer_load[c] <= upd_pulse
                               && chan_buf[c].channel_function[CF_SWEEP_LOAD];
        amp_timer_load[c] <= (upd_pulse && chan_buf[c].amplitude_control[AC_LOAD])
                             || (prof_change
                                 && chan_act[c].amplitude_control[AC_LOAD]);
      end
    end
  end

  // waveform, power and modulation levels of the channel function word
  always_ff @(posedge i_clk) begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (i_reset) begin
        sine_sel[c] <= 1'h0;
        match_pipe[c] <= 1'h0;
        dac_powerdown[c] <= 1'h0;
        digital_powerdown[c] <= 1'h0;
        dac_lsb[c] <= 2'h0;
        sweep_enable[c] <= 1'h0;
        no_dwell[c] <= 1'h0;
        mod_type[c] <= 2'h0;
      end else begin
        sine_sel[c] <= chan_act[c].channel_function[CF_SINE];
        match_pipe[c] <= chan_act[c].channel_function[CF_MATCH_PIPE];
        dac_powerdown[c] <= chan_act[c].channel_function[CF_DAC_PD];
        digital_powerdown[c] <= chan_act[c].channel_function[CF_DIG_PD];
        dac_lsb[c] <= chan_act[c].channel_function[CF_DAC_LSB_LO +: 2];
        sweep_enable[c] <= chan_act[c].channel_function[CF_SWEEP_EN];
        no_dwell[c] <= chan_act[c].channel_function[CF_NO_DWELL]
                       & chan_act[c].channel_function[CF_SWEEP_EN];
        mod_type[c] <= chan_act[c].channel_function[CF_MOD_LO +: 2];
      end
    end
  end

  // tuning, phase and sweep words
  always_ff @(posedge i_clk) begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (i_reset) begin
        freq_word[c] <= '0;
        phase_word[c] <= '0;
        sweep_rate[c] <= '0;
        rising_delta[c] <= '0;
        falling_delta[c] <= '0;
      end else begin
        freq_word[c] <= chan_act[c].channel_frequency_word_zero;
        phase_word[c] <= chan_act[c].channel_phase_offset_zero[POW_W-1:0];
        sweep_rate[c] <= chan_act[c].sweep_ramp_rate;
        rising_delta[c] <= chan_act[c].rising_delta_word;
        falling_delta[c] <= chan_act[c].falling_delta_word;
      end
    end
  end

  // amplitude path; auto ramping means nothing with the multiplier bypassed
  always_ff @(posedge i_clk) begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (i_reset) begin
        amp_scale[c] <= '0;
        amp_mult_enable[c] <= 1'h0;
        amplitude_ramp_updown[c] <= 1'h0;
        amp_step[c] <= 2'h0;
        amp_rate[c] <= 8'h00;
      end else begin
        amp_scale[c] <= chan_act[c].amplitude_control[AC_ASF_W-1:0];
        amp_mult_enable[c] <= chan_act[c].amplitude_control[AC_MULT_EN];
        amplitude_ramp_updown[c] <= chan_act[c].amplitude_control[AC_AUTO]
                                    & chan_act[c].amplitude_control[AC_MULT_EN];
        amp_step[c] <= chan_act[c].amplitude_control[AC_STEP_LO +: 2];
        amp_rate[c] <= chan_act[c].amplitude_control[AC_RATE_LO +: 8];
      end
    end
  end

  // the port carries the flops above with no logic between
  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      o_ctl[c].phase_clear = phase_clear[c];
      o_ctl[c].phase_autoclear = phase_autoclear[c];
      o_ctl[c].sweep_clear = sweep_clear[c];
      o_ctl[c].sweep_autoclear = sweep_autoclear[c];
      o_ctl[c].sine_sel = sine_sel[c];
      o_ctl[c].match_pipe = match_pipe[c];
      o_ctl[c].dac_powerdown = dac_powerdown[c];
      o_ctl[c].digital_powerdown = digital_powerdown[c];
      o_ctl[c].dac_lsb = dac_lsb[c];
      o_ctl[c].sweep_timer_load = sweep_timer_load[c];
      o_ctl[c].sweep_enable = sweep_enable[c];
      o_ctl[c].no_dwell = no_dwell[c];
      o_ctl[c].mod_type = mod_type[c];
      o_ctl[c].freq_word = freq_word[c];
      o_ctl[c].phase_word = phase_word[c];
      o_ctl[c].amp_scale = amp_scale[c];
      o_ctl[c].amp_mult_enable = amp_mult_enable[c];
      o_ctl[c].amplitude_ramp_updown = amplitude_ramp_updown[c];
      o_ctl[c].amp_timer_load = amp_timer_load[c];
      o_ctl[c].amp_step = amp_step[c];
      o_ctl[c].amp_rate = amp_rate[c];
      o_ctl[c].sweep_rate = sweep_rate[c];
      o_ctl[c].rising_delta = rising_delta[c];
      o_ctl[c].falling_delta = falling_delta[c];
    end
  end

endmodule : dcr_channel_regs

// ==== dcr_chk.sv ====
// dcr_chk: port checks of the channel control bank
module dcr_chk
  import dcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_update,
  input wire logic [3:0] i_profile,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic [7:0] o_channel_select,
  input wire dcr_chan_ctl_t [NUM_CHAN-1:0] o_ctl
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic [7:0] cs_exp;
  logic cs_wr;
  logic [3:0] prof_last;
  logic [3:0] prof_quiet;
  // cycles since the profile pins last moved, saturating
  always_ff @(posedge i_clk) begin
    prof_last <= i_profile;
    if (i_reset || i_profile != prof_last) begin
      prof_quiet <= 4'h0;
    end else if (prof_quiet != 4'hF) begin
      prof_quiet <= prof_quiet + 4'h1;
    end
  end
  assign cs_wr = i_wr && (i_addr == ADDR_CHANNEL_SELECT);
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cs_exp <= RST_CHANNEL_SELECT;
    end else if (cs_wr) begin
      cs_exp <= i_wdata[7:0];
    end
  end
  AST_CS_AT_ONCE: assert property (cs_wr |-> ##[1:2] o_channel_select == cs_exp)
    else $error("channel select copy late");
  AST_READ_ANSWER: assert property (i_rd |=> o_rvalid)
    else $error("read not answered");
  AST_WORD_ON_UPDATE: assert property ($changed(o_ctl[0].freq_word) |-> i_update)
    else $error("word moved without update");
  AST_PHASE_AUTOCLR: assert property (o_ctl[0].phase_autoclear |->
    i_update ##1 !o_ctl[0].phase_autoclear) else $error("phase autoclear pulse bad");
  AST_SWEEP_AUTOCLR: assert property (o_ctl[1].sweep_autoclear |->
    i_update ##1 !o_ctl[1].sweep_autoclear) else $error("sweep autoclear pulse bad");
  AST_SWEEP_TMR: assert property (o_ctl[2].sweep_timer_load |->
    i_update ##1 !o_ctl[2].sweep_timer_load) else $error("sweep timer load bad");
  AST_AMP_TMR: assert property (o_ctl[0].amp_timer_load |->
    i_update || prof_quiet < 4'h8) else $error("amp timer load without cause");
  AST_NO_DWELL: assert property (o_ctl[0].no_dwell |-> o_ctl[0].sweep_enable)
    else $error("no dwell without sweep");
  AST_RAMP_GATE: assert property (o_ctl[0].amplitude_ramp_updown |->
    o_ctl[0].amp_mult_enable) else $error("ramp without multiplier");
  COV_PHASE_AUTOCLR: cover property (o_ctl[0].phase_autoclear);
  COV_SWEEP_TMR: cover property (o_ctl[2].sweep_timer_load);
  COV_NO_DWELL: cover property (o_ctl[0].no_dwell);
  COV_AMP_TMR: cover property (o_ctl[0].amp_timer_load && !i_update);
endmodule : dcr_chk
bind dcr_channel_regs dcr_chk u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_wr(i_wr),
  .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .i_update(i_update),
  .i_profile(i_profile), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .o_channel_select(o_channel_select), .o_ctl(o_ctl));

// ==== dcr_host.sv ====
// dcr_host: host model, strobes driven at the falling edge
module dcr_host
  import dcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic [DATA_W-1:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_wdata,
  output logic o_update
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_wr = 1'h0;
    o_rd = 1'h0;
    o_addr = 8'h00;
    o_wdata = 32'h0;
    o_update = 1'h0;
  end
  // idle bus shows the inverse so stale values never pass for fresh ones
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = (a == ADDR_CHANNEL_FUNCTION) ? (d & ~(32'h1 << CF_MUST_ZERO)) : d;
    o_wr = 1'h1;
    @(negedge i_clk);
    o_wr = 1'h0;
    o_addr = ~a;
    o_wdata = ~o_wdata;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'h1;
    @(negedge i_clk);
    o_rd = 1'h0;
    o_addr = ~a;
    @(negedge i_clk);
    d = i_rdata;
  endtask : rd
  // pin held well past the filter, then low long enough for the next event
  task automatic upd();
    @(negedge i_clk);
    o_update = 1'h1;
    repeat (8) @(negedge i_clk);
    o_update = 1'h0;
    repeat (5) @(negedge i_clk);
  endtask : upd
endmodule : dcr_host

// ==== test_dcr_channel_regs.sv ====
// test_dcr_channel_regs: self-checking bench of the channel control bank
module test_dcr_channel_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import dcr_pkg::*;
  logic clk;
  logic reset;
  logic wr;
  logic rd;
  logic upd;
  logic rvalid;
  logic [7:0] addr;
  logic [7:0] cs;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic [15:0] seen;
  logic [3:0] prof;
  dcr_chan_ctl_t [NUM_CHAN-1:0] ctl;
  int mismatches;
  int cmp_count;
  int rvalid_cnt;
  dcr_channel_regs DUT (.i_clk(clk), .i_reset(reset), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wdata), .i_update(upd), .i_profile(prof), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_channel_select(cs), .o_ctl(ctl));
  dcr_host host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata), .o_update(upd));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (ctl[c].sweep_autoclear === 1'h1) seen[c] <= 1'h1;
      if (ctl[c].phase_autoclear === 1'h1) seen[4+c] <= 1'h1;
      if (ctl[c].sweep_timer_load === 1'h1) seen[8+c] <= 1'h1;
      if (ctl[c].amp_timer_load === 1'h1) seen[12+c] <= 1'h1;
    end
    if (rvalid === 1'h1) rvalid_cnt <= rvalid_cnt + 1;
  end
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  task automatic t_buffer();
    host.wr(ADDR_CHANNEL_SELECT, 32'h10);
    host.wr(ADDR_FREQ_WORD_ZERO, 32'h12345678);
    host.rd(ADDR_FREQ_WORD_ZERO, rv);
    chk(32'h12345678, rv);
    chk(32'h0, ctl[0].freq_word);
    host.upd();
    chk(32'h12345678, ctl[0].freq_word);
    chk(32'h0, ctl[1].freq_word);
    host.wr(ADDR_CHANNEL_SELECT, 32'h00);
    host.wr(ADDR_FREQ_WORD_ZERO, 32'hFFFFFFFF);
    host.upd();
    chk(32'h12345678, ctl[0].freq_word);
    host.wr(ADDR_CHANNEL_SELECT, 32'hF0);
  endtask : t_buffer
  task automatic t_words();
    host.wr(ADDR_PHASE_OFFSET_ZERO, 32'hFFFF);
    host.wr(ADDR_SWEEP_RAMP_RATE, 32'hBEEF);
    host.wr(ADDR_RISING_DELTA, 32'h01234567);
    host.wr(ADDR_FALLING_DELTA, 32'h89ABCDEF);
    host.upd();
    chk(32'h3FFF, 32'(ctl[3].phase_word));
    chk(32'hBEEF, 32'(ctl[3].sweep_rate));
    chk(32'h01234567, ctl[3].rising_delta);
    chk(32'h89ABCDEF, ctl[3].falling_delta);
  endtask : t_words
  task automatic t_chan_fn();
    seen = 16'h0000;
    host.wr(ADDR_CHANNEL_FUNCTION, 32'hC0E4FF);
    host.rd(ADDR_CHANNEL_FUNCTION, rv);
    chk(32'hC0E0FF, rv);
    host.upd();
    chk(32'h0FFF, 32'(seen));
    chk(32'h3FF, 32'({ctl[2].sine_sel, ctl[2].phase_clear, ctl[2].sweep_clear,
      ctl[2].match_pipe, ctl[2].dac_powerdown, ctl[2].digital_powerdown,
      ctl[2].sweep_enable, ctl[2].no_dwell, ctl[2].mod_type}));
    host.wr(ADDR_CHANNEL_FUNCTION, 32'h8000);
    seen = 16'h0000;
    host.upd();
    chk(32'h0, 32'(seen));
    chk(32'h0, 32'({ctl[2].no_dwell, ctl[2].phase_clear}));
  endtask : t_chan_fn
  task automatic t_amp();
    seen = 16'h0000;
    host.wr(ADDR_AMPLITUDE_CONTROL, 32'hA5DF7B);
    host.upd();
    chk(32'hF000, 32'(seen));
    seen = 16'h0000;
    prof = 4'h5;
    repeat (8) @(negedge clk);
    chk(32'hF000, 32'(seen));
    chk({10'h0, 8'hA5, 2'h3, 1'h1, 1'h1, 10'h37B}, 32'({ctl[0].amp_rate,
      ctl[0].amp_step, ctl[0].amplitude_ramp_updown, ctl[0].amp_mult_enable,
      ctl[0].amp_scale}));
    host.wr(ADDR_AMPLITUDE_CONTROL, 32'h800);
    host.upd();
    seen = 16'h0000;
    prof = 4'h0;
    repeat (8) @(negedge clk);
    chk(32'h0, 32'(seen));
    chk(32'h0, 32'(ctl[0].amplitude_ramp_updown));
  endtask : t_amp
  task automatic t_global();
    @(negedge clk);
    seen = 16'h0000;
    host.wr(ADDR_GLOBAL_FUNCTION_TWO, 32'hF000);
    host.upd();
    chk(32'hFF, 32'(seen));
    chk(32'h3, 32'({ctl[3].phase_clear, ctl[3].sweep_clear}));
    host.wr(ADDR_GLOBAL_FUNCTION_TWO, 32'h0);
    host.upd();
    chk(32'h0, 32'({ctl[3].phase_clear, ctl[3].sweep_clear}));
    host.wr(8'h1F, 32'hDEADBEEF);
    host.rd(8'h1F, rv);
    chk(32'h0, rv);
  endtask : t_global
  initial begin
    reset = 1'h1;
    seen = 16'h0000;
    prof = 4'h0;
    rvalid_cnt = 0;
    mismatches = 0;
    cmp_count = 0;
    repeat (2) @(negedge clk);
    reset = 1'h0;
    chk(32'(RST_CHANNEL_SELECT), 32'(cs));
    chk(32'h0, 32'(ctl[0].dac_lsb));
    t_buffer();
    t_words();
    t_chan_fn();
    t_amp();
    t_global();
    chk(32'h3, 32'(rvalid_cnt));
    summarize();
  end
  // whole run is under two hundred cycles; this cuts a hang short
  initial begin
    #50000;
    mismatches++;
    summarize();
  end
endmodule : test_dcr_channel_regs
